/* File: common/tcw_pkg.sv */
/*
  Shared constants and types for the timer / capture-compare / watchdog block.
  Assumes a single 10 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
package tcw_pkg;

  localparam int TCW_ADDR_W = 16;
  localparam int TCW_IDX_W = 14;

  // Register indices; the byte address is four times the index
  localparam logic [13:0] IDX_CLOCK_SELECT = 14'h1048;
  localparam logic [13:0] IDX_WATCHDOG_CTL_B = 14'h104A;
  localparam logic [13:0] IDX_FLAG_CTL_C = 14'h104B;
  localparam logic [13:0] IDX_MODE_CTL_D = 14'h104C;
  localparam logic [13:0] IDX_COMPARE = 14'h104D;
  localparam logic [13:0] IDX_CAPTURE_COMPARE = 14'h104E;
  localparam logic [13:0] IDX_COUNTER = 14'h104F;
  localparam logic [13:0] IDX_WATCHDOG_COUNT = 14'h1050;
  localparam logic [13:0] IDX_PORT_CTL_A = 14'h1051;
  localparam logic [13:0] IDX_PORT_CTL_B = 14'h1052;

  // Bit positions in timer_watchdog_control_b
  localparam int WB_RESET_ENA = 7;
  localparam int WB_INT_ENA = 6;
  localparam int WB_OVF_FLAG = 5;
  localparam int WB_TAP_SEL = 4;
  localparam int WB_CNT_OVF_FLAG = 3;
  localparam int WB_CNT_OVF_IE = 2;

  // Bit positions in timer_flag_control_c
  localparam int FC_EDGE_FLAG = 7;
  localparam int FC_CMP2_FLAG = 6;
  localparam int FC_CMP1_FLAG = 5;
  localparam int FC_EDGE_IE = 2;
  localparam int FC_CMP2_IE = 1;
  localparam int FC_CMP1_IE = 0;

  // Reset values
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h33;
  localparam logic [7:0] RST_CTL_B = 8'h00;
  localparam logic [7:0] RST_CTL_C = 8'h00;
  localparam logic [7:0] RST_CTL_D = 8'h00;
  localparam logic [15:0] RST_COMPARE = 16'hFFFF;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;
  localparam logic [7:0] RST_PORT_A = 8'h00;
  localparam logic [7:0] RST_PORT_B = 8'h00;

  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [14:0] WD_SHORT_MAX = 15'h7FFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_SYSTEM_CLOCK = 3'b000,
    SRC_PULSE_ACC = 3'b001,
    SRC_EVENT = 3'b010,
    SRC_STOP = 3'b011,
    SRC_DIV4 = 3'b100,
    SRC_DIV16 = 3'b101,
    SRC_DIV64 = 3'b110,
    SRC_DIV256 = 3'b111
  } tcw_clksrc_e;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_RESP = 1'b1
  } tcw_bus_e;

  // timer_mode_control_d layout
  typedef struct packed {
    logic captureModeSelect;
    logic compareOneOutputEnable;
    logic compareTwoOutputEnable;
    logic spare;
    logic edgeOutputEnable;
    logic edgeFallingSelect;
    logic edgeResetEnable;
    logic edgeDetectEnable;
  } tcw_mode_s;

endpackage

/* File: logic/tcw_timer.sv */
/*
  Timer with compare, capture/compare and PWM output, plus a separate watchdog counter,
  behind an AXI4-Lite slave. Assumes pins are asynchronous and that the event pin toggles
  at no more than half the system clock rate.
*/
// The AXI4-Lite slave port was left to the implementer.
// Summary of operation
// - Eight clock sources: system_clock, pulse accumulate, event, /4, /16, /64, /256, stopped.
// - Timer and watchdog select their clock sources independently.
// - Timer holds 16-bit counter, compare and capture/compare registers.
// - In capture mode a selected capture-pin edge latches the counter into capture/compare.
// - Watchdog is a separate 16-bit counter; overflow tap gives 15 to 24 bit resolution.
// - Without reset use, watchdog works as timer, event counter or pulse accumulator.
// - Capture-pin edge sets the edge flag when edge detect is enabled.
// - Dual compare mode: edge resets counter and/or toggles PWM per enables.
// - Capture mode: enabled edge loads capture register and sets the edge flag.
// - Compare match sets compare-one flag; toggles PWM in dual mode when enabled.
// - Dual mode only: capture/compare match sets compare-two flag, may toggle PWM.
// - Counter wrap from all ones to zero sets the counter overflow flag.
// - Watchdog overflow sets its flag and resets the system when reset is enabled.
// - Watchdog overflow interrupts without reset when reset disabled and interrupt enabled.
// - Each of the three pins is timer function or general-purpose I/O by port control.
// - Mode bit clear selects dual compare mode with two compare registers.
// - Mode bit set selects capture/compare mode: one compare, one capture register.
// - Flag control register sits at index 104Bh.
module tcw_timer
  import tcw_pkg::*;
#(
  parameter int PRESCALE_W = 8
) (
  // Clock and reset
  input logic clk,
  input logic rst,
  // AXI4-Lite write
  input logic [15:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read
  input logic [15:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Pins: event input, capture input, waveform output (index 0, 1, 2)
  input logic [2:0] pinIn,
  output logic [2:0] pinOut,
  output logic [2:0] pinOe,
  // System
  output logic timerIrq,
  output logic watchdogResetOut
);

  logic [2:0] pinSync1;
  logic [2:0] pinSync2;
  logic [2:0] pinPrev;
  logic [7:0] clockSelect, next_clockSelect;
  logic [7:0] ctlB, next_ctlB;
  logic [7:0] ctlC, next_ctlC;
  logic [7:0] ctlD, next_ctlD;
  logic [7:0] portA, next_portA;
  logic [7:0] portB, next_portB;
  logic [15:0] compareReg, next_compareReg;
  logic [15:0] captureReg, next_captureReg;
  logic [15:0] counter, next_counter;
  logic [15:0] wdCounter, next_wdCounter;
  logic [PRESCALE_W-1:0] prescale, next_prescale;
  logic pwmLevel, next_pwmLevel;
  logic wdResetPulse, next_wdResetPulse;
  tcw_bus_e wrState, next_wrState;
  logic awHeld, next_awHeld;
  logic wHeld, next_wHeld;
  logic [15:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic [1:0] bResp, next_bResp;
  logic rValid, next_rValid;
  logic [31:0] rData, next_rData;
  logic [1:0] rResp, next_rResp;

  tcw_mode_s mode;
  logic evtRise, capEdge, edgeEvent, timerTick, wdTick;
  logic cmp1Match, cmp2Match, cntOverflow, edgeReset, wdOverflow;
  logic awFire, wFire, doWrite, arFire;
  logic [15:0] wrAddr;
  logic [31:0] wrData, rdWord;
  logic [3:0] wrStrb;
  logic [13:0] wrIdx, rdIdx;
  logic wrHit, rdHit;

  // Two flip-flops per pin before any logic reads it
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          pinSync1[gi] <= 1'b0;
          pinSync2[gi] <= 1'b0;
          pinPrev[gi] <= 1'b0;
        end else begin
          pinSync1[gi] <= pinIn[gi];
          pinSync2[gi] <= pinSync1[gi];
          pinPrev[gi] <= pinSync2[gi];
        end
      end
    end
  endgenerate

  // Selects one count tick; each counter passes its own source field
  function automatic logic sourceTick(input logic [2:0] src, input logic [PRESCALE_W-1:0] pre,
                                      input logic evtLevel, input logic evtEdge);
    logic t;
    t = 1'b0;
    case (tcw_clksrc_e'(src))
      SRC_SYSTEM_CLOCK: t = 1'b1;
      SRC_PULSE_ACC: t = evtLevel;
      SRC_EVENT: t = evtEdge;
      SRC_STOP: t = 1'b0;
      SRC_DIV4: t = &pre[1:0];
      SRC_DIV16: t = &pre[3:0];
      SRC_DIV64: t = &pre[5:0];
      SRC_DIV256: t = &pre[7:0];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction

  assign mode = tcw_mode_s'(ctlD);
  // Edge detection reads only the second and third stages
  assign evtRise = pinSync2[0] & ~pinPrev[0];
  assign capEdge = mode.edgeFallingSelect ? (pinPrev[1] & ~pinSync2[1]) : (pinSync2[1] & ~pinPrev[1]);
  assign edgeEvent = capEdge & mode.edgeDetectEnable;
  assign timerTick = sourceTick(clockSelect[2:0], prescale, pinSync2[0], evtRise);
  assign wdTick = sourceTick(clockSelect[6:4], prescale, pinSync2[0], evtRise);
  assign edgeReset = edgeEvent & ~mode.captureModeSelect & mode.edgeResetEnable;
  assign cmp1Match = timerTick & (counter == compareReg);
  assign cmp2Match = timerTick & ~mode.captureModeSelect & (counter == captureReg);
  assign cntOverflow = timerTick & ~edgeReset & (counter == CNT_MAX);
  // Tap select halves the overflow point, giving 15 to 24 bits with the prescaler
  assign wdOverflow = wdTick & (ctlB[WB_TAP_SEL] ? (wdCounter[14:0] == WD_SHORT_MAX)
                                                 : (wdCounter == CNT_MAX));

  // Bus handshake terms
  assign awFire = s_axi_awvalid & s_axi_awready;
  assign wFire = s_axi_wvalid & s_axi_wready;
  assign wrAddr = awHeld ? awAddr : s_axi_awaddr;
  assign wrData = wHeld ? wData : s_axi_wdata;
  assign wrStrb = wHeld ? wStrb : s_axi_wstrb;
  assign doWrite = (wrState == BUS_IDLE) & (awHeld | awFire) & (wHeld | wFire);
  assign wrIdx = wrAddr[15:2];
  assign arFire = s_axi_arvalid & s_axi_arready;
  assign rdIdx = s_axi_araddr[15:2];
  assign wrHit = (wrIdx >= IDX_CLOCK_SELECT) && (wrIdx <= IDX_PORT_CTL_B) && (wrIdx != 14'h1049);
  assign rdHit = (rdIdx >= IDX_CLOCK_SELECT) && (rdIdx <= IDX_PORT_CTL_B) && (rdIdx != 14'h1049);

  always_comb begin
    rdWord = 32'h0000_0000;
    case (rdIdx)
      IDX_CLOCK_SELECT: rdWord[7:0] = clockSelect;
      IDX_WATCHDOG_CTL_B: rdWord[7:0] = ctlB;
      IDX_FLAG_CTL_C: rdWord[7:0] = ctlC;
      IDX_MODE_CTL_D: rdWord[7:0] = ctlD;
      IDX_COMPARE: rdWord[15:0] = compareReg;
      IDX_CAPTURE_COMPARE: rdWord[15:0] = captureReg;
      IDX_COUNTER: rdWord[15:0] = counter;
      IDX_WATCHDOG_COUNT: rdWord[15:0] = wdCounter;
      IDX_PORT_CTL_A: rdWord[7:0] = portA;
      IDX_PORT_CTL_B: rdWord[10:0] = {pinSync2, portB};
      default: rdWord = 32'h0000_0000;
    endcase
  end

  // Bus state
  always_comb begin
    next_wrState = wrState;
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    case (wrState)
      BUS_IDLE: begin
        if (awFire) begin
          next_awHeld = 1'b1;
          next_awAddr = s_axi_awaddr;
        end
        if (wFire) begin
          next_wHeld = 1'b1;
          next_wData = s_axi_wdata;
          next_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
          next_awHeld = 1'b0;
          next_wHeld = 1'b0;
          next_bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
          next_wrState = BUS_RESP;
        end
      end
      BUS_RESP: begin
        if (s_axi_bready) begin
          next_wrState = BUS_IDLE;
        end
      end
      default: next_wrState = BUS_IDLE;
    endcase
    if (arFire) begin
      next_rValid = 1'b1;
      next_rData = rdWord;
      next_rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrState <= BUS_IDLE;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 16'h0000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      bResp <= 2'h0;
      rValid <= 1'b0;
      rData <= 32'h0000_0000;
      rResp <= 2'h0;
    end else begin
      wrState <= next_wrState;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end

  assign s_axi_awready = (wrState == BUS_IDLE) & ~awHeld;
  assign s_axi_wready = (wrState == BUS_IDLE) & ~wHeld;
  assign s_axi_bvalid = (wrState == BUS_RESP);
  assign s_axi_bresp = bResp;
  assign s_axi_arready = ~rValid;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  // Timer, watchdog and control registers. Flags clear by writing one; a hardware set in
  // the same cycle wins so no event is lost.
  always_comb begin
    logic [31:0] m;
    logic pwmToggle;
    m = 32'h0000_0000;
    pwmToggle = 1'b0;
    next_clockSelect = clockSelect;
    next_ctlB = ctlB;
    next_ctlC = ctlC;
    next_ctlD = ctlD;
    next_portA = portA;
    next_portB = portB;
    next_compareReg = compareReg;
    next_captureReg = captureReg;
    next_counter = counter;
    next_wdCounter = wdCounter;
    next_prescale = prescale + 1'b1;
    next_wdResetPulse = 1'b0;
    if (doWrite) begin
      case (wrIdx)
        IDX_CLOCK_SELECT: begin
          m = mergeBytes({24'h0, clockSelect}, wrData, wrStrb);
          next_clockSelect = {1'b0, m[6:4], 1'b0, m[2:0]};
        end
        IDX_WATCHDOG_CTL_B: begin
          m = mergeBytes({24'h0, ctlB}, wrData, wrStrb);
          next_ctlB = {m[7:6], ctlB[5] & ~(wrStrb[0] & wrData[5]), m[4],
                       ctlB[3] & ~(wrStrb[0] & wrData[3]), m[2], 2'b00};
        end
        IDX_FLAG_CTL_C: begin
          m = mergeBytes({24'h0, ctlC}, wrData, wrStrb);
          next_ctlC = {ctlC[7:5] & ~({3{wrStrb[0]}} & wrData[7:5]), 2'b00, m[2:0]};
        end
        IDX_MODE_CTL_D: begin
          m = mergeBytes({24'h0, ctlD}, wrData, wrStrb);
          next_ctlD = m[7:0] & 8'hEF;
        end
        IDX_COMPARE: begin
          m = mergeBytes({16'h0, compareReg}, wrData, wrStrb);
          next_compareReg = m[15:0];
        end
        IDX_CAPTURE_COMPARE: begin
          m = mergeBytes({16'h0, captureReg}, wrData, wrStrb);
          next_captureReg = m[15:0];
        end
        IDX_WATCHDOG_COUNT: next_wdCounter = 16'h0000;
        IDX_PORT_CTL_A: begin
          m = mergeBytes({24'h0, portA}, wrData, wrStrb);
          next_portA = {5'h00, m[2:0]};
        end
        IDX_PORT_CTL_B: begin
          m = mergeBytes({24'h0, portB}, wrData, wrStrb);
          next_portB = {1'b0, m[6:4], 1'b0, m[2:0]};
        end
        default: m = 32'h0000_0000;
      endcase
    end
    if (edgeReset) begin
      next_counter = 16'h0000;
    end else if (timerTick) begin
      next_counter = counter + 1'b1;
    end
    if (edgeEvent && mode.captureModeSelect) begin
      next_captureReg = counter;
    end
    if (wdTick && !(doWrite && wrIdx == IDX_WATCHDOG_COUNT)) begin
      next_wdCounter = wdOverflow ? 16'h0000 : wdCounter + 1'b1;
    end
    if (edgeEvent) begin
      next_ctlC[FC_EDGE_FLAG] = 1'b1;
    end
    if (cmp1Match) begin
      next_ctlC[FC_CMP1_FLAG] = 1'b1;
    end
    if (cmp2Match) begin
      next_ctlC[FC_CMP2_FLAG] = 1'b1;
    end
    if (cntOverflow) begin
      next_ctlB[WB_CNT_OVF_FLAG] = 1'b1;
    end
    if (wdOverflow) begin
      next_ctlB[WB_OVF_FLAG] = 1'b1;
      next_wdResetPulse = ctlB[WB_RESET_ENA];
    end
    if (!mode.captureModeSelect) begin
      pwmToggle = (edgeEvent & mode.edgeOutputEnable)
                ^ (cmp1Match & mode.compareOneOutputEnable)
                ^ (cmp2Match & mode.compareTwoOutputEnable);
    end
    next_pwmLevel = pwmLevel ^ pwmToggle;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clockSelect <= RST_CLOCK_SELECT;
      ctlB <= RST_CTL_B;
      ctlC <= RST_CTL_C;
      ctlD <= RST_CTL_D;
      portA <= RST_PORT_A;
      portB <= RST_PORT_B;
      compareReg <= RST_COMPARE;
      captureReg <= RST_CAPTURE;
      counter <= 16'h0000;
      wdCounter <= 16'h0000;
      prescale <= '0;
      pwmLevel <= 1'b0;
      wdResetPulse <= 1'b0;
    end else begin
      clockSelect <= next_clockSelect;
      ctlB <= next_ctlB;
      ctlC <= next_ctlC;
      ctlD <= next_ctlD;
      portA <= next_portA;
      portB <= next_portB;
      compareReg <= next_compareReg;
      captureReg <= next_captureReg;
      counter <= next_counter;
      wdCounter <= next_wdCounter;
      prescale <= next_prescale;
      pwmLevel <= next_pwmLevel;
      wdResetPulse <= next_wdResetPulse;
    end
  end

  // Timer function turns event and capture pins into inputs and drives the waveform pin
  assign pinOe = {portA[2] | portB[6], ~portA[1] & portB[5], ~portA[0] & portB[4]};
  assign pinOut = {portA[2] ? pwmLevel : portB[2], portB[1:0]};
  assign watchdogResetOut = wdResetPulse;
  assign timerIrq = (ctlC[FC_EDGE_FLAG] & ctlC[FC_EDGE_IE]) | (ctlC[FC_CMP1_FLAG] & ctlC[FC_CMP1_IE])
                  | (ctlC[FC_CMP2_FLAG] & ctlC[FC_CMP2_IE]) | (ctlB[WB_CNT_OVF_FLAG] & ctlB[WB_CNT_OVF_IE])
                  | (ctlB[WB_OVF_FLAG] & ~ctlB[WB_RESET_ENA] & ctlB[WB_INT_ENA]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_capture_load;
    edgeEvent && mode.captureModeSelect |=> captureReg == $past(counter);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture missed counter value");
  property p_edge_flag;
    edgeEvent |=> ctlC[FC_EDGE_FLAG];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag not set");
  property p_edge_reset;
    edgeEvent && !mode.captureModeSelect && mode.edgeResetEnable |=> counter == 16'h0000;
  endproperty
  a_edge_reset: assert property (p_edge_reset) else $error("edge did not reset counter");
  property p_overflow;
    timerTick && counter == CNT_MAX && !edgeReset |=> counter == 16'h0000 && ctlB[WB_CNT_OVF_FLAG];
  endproperty
  a_overflow: assert property (p_overflow) else $error("counter wrap not flagged");
  property p_cmp1;
    cmp1Match && !mode.captureModeSelect && mode.compareOneOutputEnable && !cmp2Match && !edgeEvent
      |=> ctlC[FC_CMP1_FLAG] && pwmLevel != $past(pwmLevel);
  endproperty
  a_cmp1: assert property (p_cmp1) else $error("compare one did not toggle");
  property p_cmp2_mode;
    mode.captureModeSelect && !ctlC[FC_CMP2_FLAG] |=> !ctlC[FC_CMP2_FLAG];
  endproperty
  a_cmp2_mode: assert property (p_cmp2_mode) else $error("compare two active in capture mode");
  property p_wd_reset;
    wdOverflow && ctlB[WB_RESET_ENA] |=> watchdogResetOut ##1 !watchdogResetOut;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset pulse wrong");
  property p_wd_irq;
    wdOverflow && !ctlB[WB_RESET_ENA] && ctlB[WB_INT_ENA] |=> timerIrq && !watchdogResetOut;
  endproperty
  a_wd_irq: assert property (p_wd_irq) else $error("watchdog interrupt missing");
  property p_stopped;
    clockSelect[2:0] == SRC_STOP && !edgeReset |=> counter == $past(counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");
  property p_pwm_pin;
    portA[2] |-> pinOe[2] && pinOut[2] == pwmLevel;
  endproperty
  a_pwm_pin: assert property (p_pwm_pin) else $error("waveform pin not driven");

  c_capture: cover property (edgeEvent && mode.captureModeSelect);
  c_pwm_toggle: cover property (cmp1Match ##[1:300] cmp2Match);
  c_wd_reset: cover property (wdOverflow && ctlB[WB_RESET_ENA]);

endmodule

/* File: verif/tcw_pin_model.sv */
/*
  Board-side model of the three timer pins: event source, capture source and waveform pin readback.
  Assumes the tasks are called from the bench between clock edges' updates.
*/
module tcw_pin_model (
  // Clock
  input wire logic clk,
  // Pins seen from the board
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe,
  output logic [2:0] pinIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic evtLevel = 1'b0;
  logic capLevel = 1'b0;
  logic lastWave = 1'b0;
  always @(posedge clk) if (pinOe[2]) lastWave <= pinOut[2];
  // Undriven waveform pin shows the opposite of its last level, so a stale read cannot pass
  assign pinIn = {pinOe[2] ? pinOut[2] : ~lastWave, capLevel, evtLevel};
  task automatic capturePulse();
    @(posedge clk) capLevel <= 1'b1;
    repeat (4) @(posedge clk);
    capLevel <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Two cycles high, two low: well inside half the system clock rate
  task automatic eventPulses(input int n);
    repeat (n) begin
      @(posedge clk) evtLevel <= 1'b1;
      repeat (2) @(posedge clk);
      evtLevel <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic eventHold(input int n);
    @(posedge clk) evtLevel <= 1'b1;
    repeat (n) @(posedge clk);
    evtLevel <= 1'b0;
  endtask
endmodule

/* File: verif/test_tcw_timer.sv */
/*
  Self-checking bench for tcw_timer: AXI4-Lite register tasks and pin scenarios.
  Assumes tcw_pin_model on the pins and a 10 MHz clock.
*/
module test_tcw_timer
  import tcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, wdRst;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, v;
  logic [2:0] pinIn, pinOut, pinOe;
  int errCount = 0, cmpCount = 0, cyc = 0, pulses = 0, t0 = 0;
  int srcTab[8] = '{0, 4, 5, 6, 7, 3, 2, 1};
  int expTab[8] = '{1024, 256, 64, 16, 4, 0, 20, 100};

  tcw_timer #(.PRESCALE_W(8)) u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .timerIrq(irq), .watchdogResetOut(wdRst));
  tcw_pin_model u_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && wdRst === 1'b1) pulses <= pulses + 1;
    if (cyc == 90000) begin
      errCount++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkNear(input logic [15:0] g, input int e, input int tol);
    cmpCount++;
    if (^g === 1'bx || int'(g) < e - tol || int'(g) > e + tol) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Ready and valid are looked at mid-cycle, so the edge that takes them is known without a race
  task automatic wr(input logic [13:0] i, input logic [31:0] dv, output logic [1:0] rs);
    bit a, w, b;
    int n;
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 0;
    n = 0;
    while (!b && n < 200) begin
      @(negedge clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = (bvalid === 1'b1);
      rs = bresp;
      n++;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) begin
      errCount++;
      conclude();
    end
  endtask
  task automatic rd(input logic [13:0] i, output logic [31:0] dv, output logic [1:0] rs);
    bit a, b;
    int n;
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 0;
    n = 0;
    while (!b && n < 200) begin
      @(negedge clk);
      a = arvalid && arready;
      b = (rvalid === 1'b1);
      dv = rdata;
      rs = rresp;
      n++;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (b) rready <= 1'b0;
    end
    if (!b) begin
      errCount++;
      conclude();
    end
  endtask
  task automatic rdChk(input logic [13:0] i, input logic [31:0] e);
    logic [31:0] dv;
    logic [1:0] rs;
    rd(i, dv, rs);
    chk(dv, e);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask
  task automatic waitTo(input int n);
    while (cyc < t0 + n) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdChk(IDX_CLOCK_SELECT, {24'h0, RST_CLOCK_SELECT});
    rdChk(IDX_WATCHDOG_CTL_B, 32'h0);
    rdChk(IDX_FLAG_CTL_C, 32'h0);
    rdChk(IDX_MODE_CTL_D, 32'h0);
    rdChk(IDX_COMPARE, {16'h0, RST_COMPARE});
    rdChk(IDX_CAPTURE_COMPARE, 32'h0);
    wr(14'h1049, 32'hFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(14'h1049, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // Pins as plain I/O: waveform pin driven high, the other two read back
    wr(IDX_PORT_CTL_B, 32'h45, r);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({29'h0, pinOe}, 32'h4);
    chk({29'h0, pinOut}, 32'h5);
    rdChk(IDX_PORT_CTL_B, 32'h445);
    for (int k = 0; k < 8; k++) begin
      rd(IDX_COUNTER, v, r);
      wr(IDX_CLOCK_SELECT, 32'h30 | 32'(srcTab[k]), r);
      if (srcTab[k] == 2) u_pins.eventPulses(20);
      else if (srcTab[k] == 1) u_pins.eventHold(100);
      else repeat (1024) @(posedge clk);
      wr(IDX_CLOCK_SELECT, 32'h33, r);
      rd(IDX_COUNTER, d, r);
      chkNear(d[15:0] - v[15:0], expTab[k], 3);
    end
    rdChk(IDX_WATCHDOG_COUNT, 32'h0);
    wr(IDX_PORT_CTL_A, 32'h7, r);
    wr(IDX_MODE_CTL_D, 32'h81, r);
    wr(IDX_FLAG_CTL_C, 32'hE4, r);
    rd(IDX_COUNTER, v, r);
    u_pins.capturePulse();
    rdChk(IDX_CAPTURE_COMPARE, v);
    rdChk(IDX_FLAG_CTL_C, 32'h84);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_FLAG_CTL_C, 32'h84, r);
    rdChk(IDX_FLAG_CTL_C, 32'h04);
    wr(IDX_COMPARE, 32'h100, r);
    wr(IDX_CAPTURE_COMPARE, 32'h200, r);
    wr(IDX_MODE_CTL_D, 32'h67, r);
    u_pins.capturePulse();
    rdChk(IDX_COUNTER, 32'h0);
    wr(IDX_FLAG_CTL_C, 32'hE3, r);
    wr(IDX_WATCHDOG_CTL_B, 32'h50, r);
    wr(IDX_CLOCK_SELECT, 32'h00, r);
    t0 = cyc;
    waitTo(32'h100 - 20);
    chk({31'h0, pinOut[2]}, 32'h0);
    rdChk(IDX_FLAG_CTL_C, 32'h03);
    waitTo(32'h100 + 20);
    chk({31'h0, pinOut[2]}, 32'h1);
    rdChk(IDX_FLAG_CTL_C, 32'h23);
    waitTo(32'h200 + 20);
    chk({31'h0, pinOut[2]}, 32'h0);
    rdChk(IDX_FLAG_CTL_C, 32'h63);
    wr(IDX_FLAG_CTL_C, 32'hE0, r);
    waitTo(32768 - 30);
    rdChk(IDX_WATCHDOG_CTL_B, 32'h50);
    chk({31'h0, irq}, 32'h0);
    waitTo(32768 + 30);
    rdChk(IDX_WATCHDOG_CTL_B, 32'h70);
    chk({31'h0, irq}, 32'h1);
    chk(32'(pulses), 32'h0);
    wr(IDX_WATCHDOG_CTL_B, 32'hF4, r);
    waitTo(65536 - 30);
    rdChk(IDX_WATCHDOG_CTL_B, 32'hD4);
    chk(32'(pulses), 32'h0);
    waitTo(65536 + 30);
    rdChk(IDX_WATCHDOG_CTL_B, 32'hFC);
    chk(32'(pulses), 32'h1);
    conclude();
  end
endmodule
